// *** shared/lcdf_map.svh ***
// Constants for the LCD driver serial command front end.
`ifndef LCDF_MAP_SVH
`define LCDF_MAP_SVH
`define LCDF_ADDR_HI      6'h1C
`define LCDF_CONT_BIT     7
`define LCDF_DP_MAX       6'h27
`define LCDF_DEVSEL_PAT   4'hC
`define LCDF_BANK_PAT     5'h1E
`define LCDF_BLINK_PAT    4'hE
`define LCDF_MODE_STATIC  2'h1
`define LCDF_MODE_DUPLEX  2'h2
`define LCDF_RST_MODE     2'h1
`endif

// *** shared/lcdf_pkg.sv ***
// Types for the LCD driver serial command front end.
package lcdf_pkg;
  typedef enum logic [2:0] {
    LCDF_CMD_NONE,
    LCDF_CMD_MODE,
    LCDF_CMD_POINTER,
    LCDF_CMD_DEVICE,
    LCDF_CMD_BANK,
    LCDF_CMD_BLINK
  } lcdf_cmd_t;
  typedef enum logic [2:0] {
    LCDF_ST_IDLE,
    LCDF_ST_ADDR,
    LCDF_ST_CMD,
    LCDF_ST_DATA,
    LCDF_ST_IGNORE
  } lcdf_state_t;
endpackage

// *** logic/lcdf_front_end.sv ***
// Serial slave receiver, command decoder and data byte steering for the LCD driver.
`timescale 1ns/1ps
`include "lcdf_map.svh"

// Operation
// - Both lines high means bus idle.
// - Data falling with clock high is START.
// - Data rising with clock high is STOP.
// - One bit per clock, stable while high.
// - Each byte followed by acknowledge cycle.
// - Acknowledge holds data low through pulse.
// - Answer only addresses 0111000 and 0111001.
// - Address bit zero equals select strap.
// - Receive only, never answers reads.
// - Matching devices acknowledge address; others ignore.
// - All matched devices acknowledge command bytes.
// - Bit seven set means another command.
// - Decode five commands from opcode bits.
// - Data byte written at pointer, subaddress.
// - Data acknowledge only on subaddress match.
// - Drive mode field selects backplane count.
// - Enable bit three blanks or enables.
// - Bias bit two, ignored when static.
// - Pointer command loads six-bit pointer.
// - Device select loads subaddress counter.
// - Bank select only in static, duplex.
// - Blink select; normal forced at high mux.
module lcdf_front_end (
  input  wire logic       i_clk,                 // System clock, 40 MHz.
  input  wire logic       i_reset_n,             // Asynchronous reset, active low.
  input  wire logic       i_scl,                 // Serial clock, clocks the link logic.
  input  wire logic       i_sda,                 // Serial data line level.
  output logic            o_sda_out,             // Serial data drive value, always low.
  output logic            o_sda_oe,              // High while pulling data low.
  input  wire logic       i_address_select_strap,// Address bit zero strap.
  input  wire logic       i_subaddress_strap_bit0, // Hardware subaddress bit 0.
  input  wire logic       i_subaddress_strap_bit1, // Hardware subaddress bit 1.
  input  wire logic       i_subaddress_strap_bit2, // Hardware subaddress bit 2.
  output logic            o_display_enable,      // Display enabled.
  output logic            o_bias_half,           // High for one-half bias.
  output logic [1:0]      o_drive_mode,          // Backplane drive mode.
  output logic [5:0]      o_data_pointer,        // Pointer loaded by command.
  output logic [2:0]      o_subaddress,          // Subaddress counter loaded by command.
  output logic            o_input_bank,          // Input bank select.
  output logic            o_output_bank,         // Output bank select.
  output logic            o_alternate_blink_bit, // Alternate bank blinking.
  output logic [1:0]      o_blink_rate_field,    // Blink rate, zero is off.
  output logic            o_data_valid,          // One-cycle pulse with a data byte.
  output logic [7:0]      o_data_byte,           // Display data byte.
  output logic            o_data_store           // Byte is for this device.
);

  // Link domain, clocked by the serial clock. START and STOP are caught by
  // the data line edges sampled against the clock level. The link clock only
  // runs inside frames, so a condition stays pending until scl moves again.
  logic                   start_reg;
  logic                   stop_reg;
  logic                   start_clr_reg;
  logic                   stop_clr_reg;

  always_ff @(negedge i_sda or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_reg <= 1'b0;
    end else if (i_scl) begin
      start_reg <= ~start_reg;
    end
  end

  always_ff @(posedge i_sda or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stop_reg <= 1'b0;
    end else if (i_scl) begin
      stop_reg <= ~stop_reg;
    end
  end

  // A START or STOP toggles its latch; the copy taken on the rising scl edge
  // catches up one edge later, so the falling edge that follows the condition
  // still sees it pending while the next rising edge retires it.
  always_ff @(posedge i_scl or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_clr_reg <= 1'b0;
      stop_clr_reg  <= 1'b0;
    end else begin
      start_clr_reg <= start_reg;
      stop_clr_reg  <= stop_reg;
    end
  end

  logic                   frame_start;
  logic                   frame_stop;
  assign frame_start = start_reg ^ start_clr_reg;
  assign frame_stop  = stop_reg ^ stop_clr_reg;

  lcdf_pkg::lcdf_state_t  state_reg, state_next;
  logic [3:0]             bit_cnt_reg, bit_cnt_next;
  logic [7:0]             shift_reg, shift_next;
  logic                   ack_reg, ack_next;
  logic                   byte_tgl_reg, byte_tgl_next;
  logic [7:0]             byte_hold_reg, byte_hold_next;
  logic                   byte_is_cmd_reg, byte_is_cmd_next;
  logic                   store_hold_reg, store_hold_next;
  logic [2:0]             sub_reg, sub_next;
  logic [2:0]             hw_sub;
  logic [2:0]             sub_live;
  logic [7:0]             full_byte;

  assign hw_sub    = {i_subaddress_strap_bit2, i_subaddress_strap_bit1,
                      i_subaddress_strap_bit0};
  assign full_byte = {shift_reg[6:0], i_sda};
  // A device-select in the byte just before still counts for this byte.
  assign sub_live  = sub_reg;

  always_comb begin
    state_next       = state_reg;
    bit_cnt_next     = bit_cnt_reg;
    shift_next       = shift_reg;
    ack_next         = 1'b0;
    byte_tgl_next    = byte_tgl_reg;
    byte_hold_next   = byte_hold_reg;
    byte_is_cmd_next = byte_is_cmd_reg;
    store_hold_next  = store_hold_reg;
    sub_next         = sub_reg;
    if (frame_start) begin
      state_next   = lcdf_pkg::LCDF_ST_ADDR;
      bit_cnt_next = 4'h0;
    end else if (frame_stop) begin
      state_next = lcdf_pkg::LCDF_ST_IDLE;
    end else if (state_reg != lcdf_pkg::LCDF_ST_IDLE) begin
      if (bit_cnt_reg == 4'h8) begin
        bit_cnt_next = 4'h0;
      end else begin
        shift_next   = full_byte;
        bit_cnt_next = bit_cnt_reg + 4'h1;
      end
      if (bit_cnt_reg == 4'h7) begin
        unique case (state_reg)
          lcdf_pkg::LCDF_ST_ADDR: begin
            if (full_byte[7:2] == `LCDF_ADDR_HI &&
                full_byte[1] == i_address_select_strap && !full_byte[0]) begin
              ack_next   = 1'b1;
              state_next = lcdf_pkg::LCDF_ST_CMD;
            end else begin
              state_next = lcdf_pkg::LCDF_ST_IGNORE;
            end
          end
          lcdf_pkg::LCDF_ST_CMD: begin
            ack_next         = 1'b1;
            byte_tgl_next    = ~byte_tgl_reg;
            byte_hold_next   = full_byte;
            byte_is_cmd_next = 1'b1;
            if (full_byte[6:3] == `LCDF_DEVSEL_PAT) begin
              sub_next = full_byte[2:0];
            end
            if (!full_byte[`LCDF_CONT_BIT]) begin
              state_next = lcdf_pkg::LCDF_ST_DATA;
            end
          end
          lcdf_pkg::LCDF_ST_DATA: begin
            ack_next         = (sub_live == hw_sub);
            store_hold_next  = (sub_live == hw_sub);
            byte_tgl_next    = ~byte_tgl_reg;
            byte_hold_next   = full_byte;
            byte_is_cmd_next = 1'b0;
          end
          default: begin
            state_next = lcdf_pkg::LCDF_ST_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(negedge i_scl or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg       <= lcdf_pkg::LCDF_ST_IDLE;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= 8'h00;
      byte_tgl_reg    <= 1'b0;
      byte_hold_reg   <= 8'h00;
      byte_is_cmd_reg <= 1'b0;
      store_hold_reg  <= 1'b0;
      sub_reg         <= 3'h0;
    end else begin
      state_reg       <= state_next;
      bit_cnt_reg     <= bit_cnt_next;
      shift_reg       <= shift_next;
      byte_tgl_reg    <= byte_tgl_next;
      byte_hold_reg   <= byte_hold_next;
      byte_is_cmd_reg <= byte_is_cmd_next;
      store_hold_reg  <= store_hold_next;
      sub_reg         <= sub_next;
    end
  end

  // The shift register samples on the falling edge with the bit that was
  // stable through the high phase, so the ninth falling edge closes the
  // acknowledge; driving from the falling edge keeps the line low for the
  // whole high phase of the acknowledge pulse.
  logic                   sda_oe_reg;
  always_ff @(negedge i_scl or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= ack_next & ~frame_start & ~frame_stop;
    end
  end
  assign o_sda_oe  = sda_oe_reg;
  assign o_sda_out = 1'b0;

  // System domain: the byte toggle crosses through two flip-flops, and the
  // byte fields change with the toggle and stay stable for a whole byte time after.
  logic [2:0]             tgl_sync_reg, tgl_sync_next;
  logic                   new_byte;
  assign new_byte = tgl_sync_reg[2] ^ tgl_sync_reg[1];

  logic                   enable_reg, enable_next;
  logic                   bias_reg, bias_next;
  logic                   bias_out_reg, bias_out_next;
  logic [1:0]             mode_reg, mode_next;
  logic [5:0]             ptr_reg, ptr_next;
  logic [2:0]             subout_reg, subout_next;
  logic                   ibank_reg, ibank_next;
  logic                   obank_reg, obank_next;
  logic                   ablink_reg, ablink_next;
  logic [1:0]             brate_reg, brate_next;
  logic                   dvalid_reg, dvalid_next;
  logic [7:0]             dbyte_reg, dbyte_next;
  logic                   dstore_reg, dstore_next;
  lcdf_pkg::lcdf_cmd_t    cmd;
  logic                   bank_mode;

  always_comb begin
    cmd = lcdf_pkg::LCDF_CMD_NONE;
    if (!byte_hold_reg[6]) begin
      cmd = lcdf_pkg::LCDF_CMD_POINTER;
    end else if (!byte_hold_reg[5]) begin
      cmd = lcdf_pkg::LCDF_CMD_MODE;
    end else if (byte_hold_reg[6:3] == `LCDF_DEVSEL_PAT) begin
      cmd = lcdf_pkg::LCDF_CMD_DEVICE;
    end else if (byte_hold_reg[6:2] == `LCDF_BANK_PAT) begin
      cmd = lcdf_pkg::LCDF_CMD_BANK;
    end else if (byte_hold_reg[6:3] == `LCDF_BLINK_PAT) begin
      cmd = lcdf_pkg::LCDF_CMD_BLINK;
    end
  end

  assign bank_mode = (mode_reg == `LCDF_MODE_STATIC) || (mode_reg == `LCDF_MODE_DUPLEX);

  always_comb begin
    tgl_sync_next = {tgl_sync_reg[1:0], byte_tgl_reg};
    enable_next   = enable_reg;
    bias_next     = bias_reg;
    mode_next     = mode_reg;
    ptr_next      = ptr_reg;
    subout_next   = subout_reg;
    ibank_next    = ibank_reg;
    obank_next    = obank_reg;
    ablink_next   = ablink_reg;
    brate_next    = brate_reg;
    dvalid_next   = 1'b0;
    dbyte_next    = dbyte_reg;
    dstore_next   = dstore_reg;
    if (new_byte && byte_is_cmd_reg) begin
      unique case (cmd)
        lcdf_pkg::LCDF_CMD_MODE: begin
          enable_next = byte_hold_reg[3];
          bias_next   = byte_hold_reg[2];
          mode_next   = byte_hold_reg[1:0];
        end
        lcdf_pkg::LCDF_CMD_POINTER: begin
          if (byte_hold_reg[5:0] <= `LCDF_DP_MAX) begin
            ptr_next = byte_hold_reg[5:0];
          end
        end
        lcdf_pkg::LCDF_CMD_DEVICE: begin
          subout_next = byte_hold_reg[2:0];
        end
        lcdf_pkg::LCDF_CMD_BANK: begin
          if (bank_mode) begin
            ibank_next = byte_hold_reg[1];
            obank_next = byte_hold_reg[0];
          end
        end
        lcdf_pkg::LCDF_CMD_BLINK: begin
          ablink_next = byte_hold_reg[2] & bank_mode;
          brate_next  = byte_hold_reg[1:0];
        end
        lcdf_pkg::LCDF_CMD_NONE: begin
        end
      endcase
    end else if (new_byte) begin
      dvalid_next = 1'b1;
      dbyte_next  = byte_hold_reg;
      dstore_next = store_hold_reg;
    end
    if (!bank_mode) begin
      ablink_next = 1'b0;
    end
    // Bias has no meaning in static drive, so the pin shows one-third there.
    bias_out_next = bias_next & (mode_next != `LCDF_MODE_STATIC);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tgl_sync_reg <= 3'h0;
      enable_reg   <= 1'b0;
      bias_reg     <= 1'b0;
      bias_out_reg <= 1'b0;
      mode_reg     <= `LCDF_RST_MODE;
      ptr_reg      <= 6'h00;
      subout_reg   <= 3'h0;
      ibank_reg    <= 1'b0;
      obank_reg    <= 1'b0;
      ablink_reg   <= 1'b0;
      brate_reg    <= 2'h0;
      dvalid_reg   <= 1'b0;
      dbyte_reg    <= 8'h00;
      dstore_reg   <= 1'b0;
    end else begin
      tgl_sync_reg <= tgl_sync_next;
      enable_reg   <= enable_next;
      bias_reg     <= bias_next;
      bias_out_reg <= bias_out_next;
      mode_reg     <= mode_next;
      ptr_reg      <= ptr_next;
      subout_reg   <= subout_next;
      ibank_reg    <= ibank_next;
      obank_reg    <= obank_next;
      ablink_reg   <= ablink_next;
      brate_reg    <= brate_next;
      dvalid_reg   <= dvalid_next;
      dbyte_reg    <= dbyte_next;
      dstore_reg   <= dstore_next;
    end
  end

  assign o_display_enable      = enable_reg;
  assign o_bias_half           = bias_out_reg;
  assign o_drive_mode          = mode_reg;
  assign o_data_pointer        = ptr_reg;
  assign o_subaddress          = subout_reg;
  assign o_input_bank          = ibank_reg;
  assign o_output_bank         = obank_reg;
  assign o_alternate_blink_bit = ablink_reg;
  assign o_blink_rate_field    = brate_reg;
  assign o_data_valid          = dvalid_reg;
  assign o_data_byte           = dbyte_reg;
  assign o_data_store          = dstore_reg;

  // Checks on the system side.
  property pulse_one_p;
    @(posedge i_clk) disable iff (!i_reset_n) o_data_valid |=> !o_data_valid;
  endproperty
  data_pulse_a: assert property (pulse_one_p) else $error("data valid longer than one cycle");

  bank_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !bank_mode && $stable(mode_reg) |=> $stable(ibank_reg) && $stable(obank_reg))
    else $error("bank changed in three or four way mode");

  blink_force_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !bank_mode |=> !ablink_reg) else $error("alternate blink kept at high mux");

  bias_static_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    mode_reg == `LCDF_MODE_STATIC |-> !o_bias_half) else $error("bias shown in static mode");

  ptr_range_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    ptr_reg <= `LCDF_DP_MAX) else $error("pointer beyond last address");

  sequence byte_seen_s;
    new_byte && !byte_is_cmd_reg;
  endsequence
  data_follow_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    byte_seen_s |=> o_data_valid && (o_data_store == store_hold_reg))
    else $error("data byte not presented");

  // Checks on the link side.
  ack_len_a: assert property (@(negedge i_scl) disable iff (!i_reset_n)
    o_sda_oe |=> !o_sda_oe) else $error("acknowledge longer than one bit");

  ack_place_a: assert property (@(negedge i_scl) disable iff (!i_reset_n)
    o_sda_oe |-> bit_cnt_reg == 4'h8) else $error("acknowledge outside ninth bit");

  read_quiet_a: assert property (@(negedge i_scl) disable iff (!i_reset_n)
    state_reg == lcdf_pkg::LCDF_ST_IGNORE |-> !o_sda_oe) else $error("driven while ignoring");

endmodule

// *** testbench/lcdf_bus_master.sv ***
// Behavioural serial bus master that drives the link clock and data line.
`timescale 1ns/1ps
module lcdf_bus_master (
  output logic      o_scl,    // Serial clock, stands high between frames.
  output logic      o_sda_oe, // High while the master pulls data low.
  input  wire logic i_sda     // Resolved data line level.
);
  // A quarter of the 15 ns link clock period.
  localparam real QTR = 3.75;

  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  // Opens a frame from idle, or repeats it after an acknowledge cycle.
  task automatic start();
    #(QTR) o_sda_oe = 1'b0;
    #(QTR) o_scl = 1'b1;
    #(QTR) o_sda_oe = 1'b1;
    #(QTR) o_scl = 1'b0;
  endtask

  // Sends one byte MSB first, then clocks the acknowledge bit.
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #(QTR) o_sda_oe = ~b[i];
      #(QTR) o_scl = 1'b1;
      #(2.0 * QTR) o_scl = 1'b0;
    end
    #(QTR) o_sda_oe = 1'b0;
    #(QTR) o_scl = 1'b1;
    #(QTR) ack = ~i_sda;
    #(QTR) o_scl = 1'b0;
  endtask

  // Closes the frame; both lines are left released and high afterwards.
  task automatic stop();
    #(QTR) o_sda_oe = 1'b1;
    #(QTR) o_scl = 1'b1;
    #(QTR) o_sda_oe = 1'b0;
    #(QTR);
  endtask
endmodule

// *** testbench/lcdf_front_end_tb.sv ***
// Self-checking bench for the LCD driver serial command front end.
`timescale 1ns/1ps
module lcdf_front_end_tb;
  logic       i_clk;
  logic       i_reset_n;
  logic       scl;
  logic       m_oe;
  logic       addr_strap;
  logic [2:0] sub_strap;
  logic       o_sda_out;
  logic       o_sda_oe;
  logic       o_display_enable;
  logic       o_bias_half;
  logic [1:0] o_drive_mode;
  logic [5:0] o_data_pointer;
  logic [2:0] o_subaddress;
  logic       o_input_bank;
  logic       o_output_bank;
  logic       o_alternate_blink_bit;
  logic [1:0] o_blink_rate_field;
  logic       o_data_valid;
  logic [7:0] o_data_byte;
  logic       o_data_store;
  int         err_total;
  int         tests_run;
  int         dv_count;
  int         dv_base;
  // Open-drain line with a pull-up: low whenever either party pulls.
  wire        sda = ~(m_oe | o_sda_oe);

  lcdf_front_end lcdf_front_end_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda),
    .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .i_address_select_strap(addr_strap),
    .i_subaddress_strap_bit0(sub_strap[0]), .i_subaddress_strap_bit1(sub_strap[1]),
    .i_subaddress_strap_bit2(sub_strap[2]),
    .o_display_enable(o_display_enable), .o_bias_half(o_bias_half),
    .o_drive_mode(o_drive_mode), .o_data_pointer(o_data_pointer),
    .o_subaddress(o_subaddress), .o_input_bank(o_input_bank),
    .o_output_bank(o_output_bank), .o_alternate_blink_bit(o_alternate_blink_bit),
    .o_blink_rate_field(o_blink_rate_field), .o_data_valid(o_data_valid),
    .o_data_byte(o_data_byte), .o_data_store(o_data_store)
  );

  lcdf_bus_master lcdf_bus_master_i (.o_scl(scl), .o_sda_oe(m_oe), .i_sda(sda));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Counts data pulses so a missing or doubled pulse is visible.
  initial dv_count = 0;
  always @(posedge i_clk) begin
    if (o_data_valid === 1'b1) dv_count = dv_count + 1;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] b, input logic exp_ack);
    logic ack;
    lcdf_bus_master_i.send(b, ack);
    check("acknowledge", {7'h00, ack}, {7'h00, exp_ack});
  endtask

  // Outputs cross into the system clock a few cycles after the byte.
  task automatic settle();
    repeat (10) @(negedge i_clk);
  endtask

  task automatic results();
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #50000;
    err_total++;
    results();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    i_reset_n = 1'b0;
    addr_strap = 1'b0;
    sub_strap = 3'h3;
    repeat (3) @(negedge i_clk);
    i_reset_n = 1'b1;
    settle();
    check("drive mode", {6'h00, o_drive_mode}, 8'h01);
    check("enable", {7'h00, o_display_enable}, 8'h00);
    // Other strap level and a read request must both stay silent.
    lcdf_bus_master_i.start();
    wr(8'h72, 1'b0);
    wr(8'h4F, 1'b0);
    lcdf_bus_master_i.stop();
    lcdf_bus_master_i.start();
    wr(8'h71, 1'b0);
    wr(8'h4F, 1'b0);
    lcdf_bus_master_i.stop();
    settle();
    check("enable", {7'h00, o_display_enable}, 8'h00);
    for (int m = 0; m < 4; m++) begin
      lcdf_bus_master_i.start();
      wr(8'h70, 1'b1);
      wr(8'h4C | 8'(m), 1'b1);
      lcdf_bus_master_i.stop();
      settle();
      check("drive mode", {6'h00, o_drive_mode}, 8'(m));
      check("bias", {7'h00, o_bias_half}, (m == 1) ? 8'h00 : 8'h01);
      check("enable", {7'h00, o_display_enable}, 8'h01);
    end
    // Command chain, out-of-range pointer, then one matching data byte.
    dv_base = dv_count;
    lcdf_bus_master_i.start();
    wr(8'h70, 1'b1);
    wr(8'hC2, 1'b1);
    wr(8'hA7, 1'b1);
    wr(8'hE3, 1'b1);
    wr(8'hFB, 1'b1);
    wr(8'hF5, 1'b1);
    wr(8'h28, 1'b1);
    wr(8'hA5, 1'b1);
    lcdf_bus_master_i.stop();
    settle();
    check("pointer", {2'h0, o_data_pointer}, 8'h27);
    check("subaddress", {5'h00, o_subaddress}, 8'h03);
    check("banks", {6'h00, o_input_bank, o_output_bank}, 8'h03);
    check("blink", {5'h00, o_alternate_blink_bit, o_blink_rate_field}, 8'h05);
    check("enable", {7'h00, o_display_enable}, 8'h00);
    check("drive mode", {6'h00, o_drive_mode}, 8'h02);
    check("data byte", o_data_byte, 8'hA5);
    check("store", {7'h00, o_data_store}, 8'h01);
    check("data pulses", 8'(dv_count - dv_base), 8'h01);
    // Non-matching data byte, then a repeated start in three-way mode.
    lcdf_bus_master_i.start();
    wr(8'h70, 1'b1);
    wr(8'hE5, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'h3C, 1'b0);
    lcdf_bus_master_i.start();
    wr(8'h70, 1'b1);
    wr(8'hC3, 1'b1);
    wr(8'hF8, 1'b1);
    wr(8'h75, 1'b1);
    lcdf_bus_master_i.stop();
    settle();
    check("data byte", o_data_byte, 8'h3C);
    check("store", {7'h00, o_data_store}, 8'h00);
    check("pointer", {2'h0, o_data_pointer}, 8'h00);
    check("subaddress", {5'h00, o_subaddress}, 8'h05);
    check("drive mode", {6'h00, o_drive_mode}, 8'h03);
    check("banks", {6'h00, o_input_bank, o_output_bank}, 8'h03);
    check("blink", {5'h00, o_alternate_blink_bit, o_blink_rate_field}, 8'h01);
    // The other strap level now owns the second address.
    @(negedge i_clk);
    addr_strap = 1'b1;
    settle();
    lcdf_bus_master_i.start();
    wr(8'h70, 1'b0);
    lcdf_bus_master_i.stop();
    lcdf_bus_master_i.start();
    wr(8'h72, 1'b1);
    wr(8'h4E, 1'b1);
    lcdf_bus_master_i.stop();
    settle();
    check("drive mode", {6'h00, o_drive_mode}, 8'h02);
    check("enable", {7'h00, o_display_enable}, 8'h01);
    check("bias", {7'h00, o_bias_half}, 8'h01);
    check("data line value", {7'h00, o_sda_out}, 8'h00);
    results();
  end
endmodule
